// >>> tb/bus_host_model.sv
module bus_host_model (
   input wire logic ref_clk, // clock
   input wire logic sda, // resolved data line
   output logic scl, // bus clock, idles high
   output logic sda_low, // high while pulling low
   output logic [15:0] rd_word, // last word read
   output logic rd_valid // pulse per word read
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      rd_valid = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : hw
   // data moves only while the clock is low, never faking start or stop
   task automatic bit_io(input logic b, output logic r);
      hw(3);
      sda_low = !b;
      hw(3);
      scl = 1'b1;
      hw(6);
      r = sda;
      scl = 1'b0;
   endtask : bit_io
   // sp=0 gives a (repeated) start, sp=1 a stop
   task automatic cond(input logic sp);
      hw(3);
      sda_low = sp;
      hw(3);
      scl = 1'b1;
      hw(6);
      sda_low = !sp;
      hw(6);
      scl = sp;
   endtask : cond
   task automatic xfer(input logic [7:0] d, input logic a,
         output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(a, k);
   endtask : xfer
   // k high if any byte went unacknowledged
   task automatic wr(input logic [6:0] ad, input logic [7:0] p,
         input logic [15:0] w, output logic k);
      logic [7:0] q;
      logic [3:0] n;
      cond(1'b0);
      xfer({ad, 1'b0}, 1'b1, q, n[0]);
      xfer(p, 1'b1, q, n[1]);
      xfer(w[15:8], 1'b1, q, n[2]);
      xfer(w[7:0], 1'b1, q, n[3]);
      k = |n;
      cond(1'b1);
   endtask : wr
   task automatic rd(input logic [6:0] ad, input logic [7:0] p);
      logic [7:0] q;
      logic k;
      cond(1'b0);
      xfer({ad, 1'b0}, 1'b1, q, k);
      xfer(p, 1'b1, q, k);
      cond(1'b0);
      xfer({ad, 1'b1}, 1'b1, q, k);
      xfer(8'hff, 1'b0, rd_word[15:8], k);
      xfer(8'hff, 1'b1, rd_word[7:0], k);
      cond(1'b1);
      rd_valid = 1'b1;
      hw(1);
      rd_valid = 1'b0;
   endtask : rd
endmodule : bus_host_model

// >>> tb/light_sensor_asserts.sv
module light_sensor_checker
   import light_sensor_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rst_b, // reset
   input wire logic scl_in, // bus clock
   input wire logic sda_out, // drive value
   input wire logic sda_oe, // drive enable
   input wire logic [15:0] result_value, // measurement
   input wire logic sample_done, // sample pulse
   input wire logic [15:0] upper_threshold, // limit
   input wire logic above_upper, // compare answer
   input wire logic new_sample // alert pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // lux scale without the constant factor, which cancels
   function automatic logic [26:0] lux(input logic [15:0] v);
      return 27'(v[11:0]) << v[15:12];
   endfunction : lux
   AST_RESET_VAL: assert property ($rose(rst_b) |->
      upper_threshold == 16'hbfff) else $error("limit reset wrong");
   AST_NEW_SAMPLE: assert property (sample_done |=> new_sample)
      else $error("new sample missing");
   AST_SAMPLE_CAUSE: assert property (new_sample |->
      $past(sample_done)) else $error("new sample without cause");
   AST_ABOVE: assert property ($past(rst_b) |->
      above_upper == (lux($past(result_value)) >
      lux($past(upper_threshold)))) else $error("above flag wrong");
   AST_ZERO_LOW: assert property ($past(rst_b) &&
      $past(result_value[11:0]) == 12'h000 |-> !above_upper)
      else $error("zero result above limit");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data moved with clock high");
   AST_DRIVE_LOW: assert property (sda_out == 1'b0)
      else $error("data drive not low");
   AST_LIMIT_SCL_LOW: assert property ($changed(upper_threshold) |->
      !scl_in && !$past(scl_in)) else $error("limit moved off byte end");
endmodule : light_sensor_checker

bind light_sensor_limit_id_regs light_sensor_checker chk (.ref_clk, .rst_b,
   .scl_in, .sda_out, .sda_oe, .result_value, .sample_done,
   .upper_threshold, .above_upper, .new_sample);

// >>> tb/tb.sv
`define CHK(nm, ex, ac) \
   begin \
      samples_checked++; \
      if ((ac) !== (ex)) begin \
         fails++; \
         $display("unexpected %s: expected %h seen %h", nm, ex, ac); \
      end \
   end
module tb
   import light_sensor_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] adr = 7'h44;
   localparam logic [15:0] maker = 16'h1357; // arbitrary value
   localparam logic [15:0] part = 16'h2468; // arbitrary value
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic sample_done = 1'b0;
   logic [15:0] result_value = 16'h0000;
   logic scl, sda_low, sda_out, sda_oe, above_upper, new_sample, rd_valid;
   logic [15:0] upper_threshold, rd_word, w, e;
   logic k, ex_above;
   logic [15:0] exp_q[$];
   logic [15:0] wl[3] = '{16'h0000, 16'hffff, 16'h3abc};
   logic [15:0] rl[3] = '{16'h0fff, 16'h2401, 16'h1800};
   int fails = 0;
   int samples_checked = 0;
   int seed = 27829;
   // pulled up: low while either party pulls
   wire logic sda = !(sda_low | (sda_oe & !sda_out));
   light_sensor_limit_id_regs #(.target_address(adr), .maker_code(maker),
      .part_code(part)) dut (.ref_clk, .rst_b, .scl_in(scl), .sda_in(sda),
      .sda_out, .sda_oe, .result_value, .sample_done, .upper_threshold,
      .above_upper, .new_sample);
   bus_host_model hst (.ref_clk, .sda, .scl, .sda_low, .rd_word, .rd_valid);
   always #2.5 ref_clk = ~ref_clk;
   function automatic logic [26:0] lux(input logic [15:0] v);
      return 27'(v[11:0]) << v[15:12];
   endfunction : lux
   // each finished read retires the oldest expectation
   always @(posedge ref_clk)
      if (rd_valid) begin
         e = exp_q.pop_front();
         `CHK("read word", e, rd_word)
      end
   task automatic rd_expect(input logic [7:0] p, input logic [15:0] x);
      exp_q.push_back(x);
      hst.rd(adr, p);
   endtask : rd_expect
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // bus traffic needs about 60 us; margin stays well under 100k cycles
   initial begin
      #200us;
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (5) @(negedge ref_clk);
      rd_expect(upper_threshold_offset, upper_threshold_reset);
      rd_expect(maker_identifier_offset, maker);
      rd_expect(part_identifier_offset, part);
      // a pointer owned by another slice reads zero
      rd_expect(8'h01, 16'h0000);
      // identifier writes are acked yet change nothing
      hst.wr(adr, maker_identifier_offset, 16'($random(seed)), k);
      `CHK("id write ack", 1'b0, k)
      hst.wr(adr, part_identifier_offset, 16'h0000, k);
      `CHK("id write ack", 1'b0, k)
      rd_expect(maker_identifier_offset, maker);
      rd_expect(part_identifier_offset, part);
      hst.wr(adr ^ 7'h01, upper_threshold_offset, 16'h0000, k);
      `CHK("foreign ack", 1'b1, k)
      // limits, a range code in the exponent, then random words
      for (int i = 0; i < 6; i++) begin
         w = i < 3 ? wl[i] : 16'($random(seed));
         hst.wr(adr, upper_threshold_offset, w, k);
         `CHK("limit port", w, upper_threshold)
         rd_expect(upper_threshold_offset, w);
      end
      // limit 1800 straddled by results with exponents 0 and 2, then met by 1800 itself
      w = 16'h1800;
      hst.wr(adr, upper_threshold_offset, w, k);
      for (int i = 0; i < 24; i++) begin
         result_value = i < 3 ? rl[i] : 16'($random(seed));
         ex_above = lux(result_value) > lux(w);
         repeat (2) @(negedge ref_clk);
         `CHK("above", ex_above, above_upper)
      end
      sample_done = 1'b1;
      @(negedge ref_clk);
      sample_done = 1'b0;
      `CHK("new sample", 1'b1, new_sample)
      @(negedge ref_clk);
      `CHK("new sample end", 1'b0, new_sample)
      rst_b = 1'b0;
      @(negedge ref_clk);
      `CHK("limit reset", 16'hbfff, upper_threshold)
      rst_b = 1'b1;
      repeat (5) @(negedge ref_clk);
      tally_and_finish();
   end
endmodule : tb

// >>> verilog/light_sensor_limit_id_regs.sv
// Notes on behaviour
// - exponent of upper threshold in bits 15:12, resets to b.
// - mantissa in bits 11:0, unsigned straight binary, resets to fff.
// - upper threshold at offset 03, read and write, resets to bfff.
// - upper threshold is the high limit for alert and flag logic.
// - comparison uses true result exponent regardless of mask setting.
// - maker identifier at 7e returns a fixed two-character code.
// - part identifier at 7f returns a fixed part code.
// - a new-sample pulse is offered for the alert path.
// - values compare as mantissa times two to exponent, in lux.
module light_sensor_limit_id_regs
   import light_sensor_pkg::*;
#(
   parameter logic [6:0] target_address = 7'h44, // bus address
   parameter logic [15:0] maker_code = 16'h4a4b, // arbitrary value
   parameter logic [15:0] part_code = 16'h0a51 // arbitrary value
)
(
   input wire logic ref_clk, // 200 MHz clock
   input wire logic rst_b, // asynchronous reset, active low
   input wire logic scl_in, // bus clock level
   input wire logic sda_in, // bus data level
   output logic sda_out, // bus data drive value, always low
   output logic sda_oe, // high while pulling data low
   input wire logic [15:0] result_value, // measurement, unmasked
   input wire logic sample_done, // one-cycle pulse per conversion
   output logic [15:0] upper_threshold, // limit to alert logic
   output logic above_upper, // result above upper limit
   output logic new_sample // one-cycle pulse for alert path
);
   limit_compare_if cmp_bus ();

   logic [15:0] upper_threshold_reg;
   logic scl_q_reg, sda_q_reg, scl_d_reg, sda_d_reg;
   target_state_type state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [1:0] byte_idx_reg;
   logic rw_reg;
   logic [7:0] pointer_reg;
   logic [7:0] msb_hold_reg;
   logic [15:0] tx_reg;
   logic half_reg;
   logic nack_reg;
   logic sda_oe_reg;
   logic new_sample_reg;

   // bus line events from sampled levels
   wire logic scl_rise;
   wire logic scl_fall;
   wire logic start_seen;
   wire logic stop_seen;
   assign scl_rise = scl_q_reg & ~scl_d_reg;
   assign scl_fall = ~scl_q_reg & scl_d_reg;
   assign start_seen = scl_q_reg & scl_d_reg & sda_d_reg & ~sda_q_reg;
   assign stop_seen = scl_q_reg & scl_d_reg & ~sda_d_reg & sda_q_reg;

   // byte decode
   wire logic byte_full;
   wire logic addr_match;
   wire logic write_hit;
   wire logic [15:0] write_word;
   wire logic [15:0] read_word;
   assign byte_full = bit_cnt_reg == bits_per_byte;
   assign addr_match = shift_reg[7:1] == target_address;
   // only the threshold takes writes; identifiers stay fixed
   assign write_hit = (pointer_reg == upper_threshold_offset)
      && byte_idx_reg == 2'd3;
   assign write_word = {msb_hold_reg, shift_reg};
   // unmapped pointers read zero; they belong to other slices
   assign read_word =
      (pointer_reg == upper_threshold_offset) ? upper_threshold_reg :
      (pointer_reg == maker_identifier_offset) ? maker_code :
      (pointer_reg == part_identifier_offset) ? part_code :
      16'h0000;

   // next byte to shift out: low half from tx_reg, else fresh word
   wire logic [15:0] tx_word;
   assign tx_word = half_reg ? read_word : tx_reg;

   // comparator sees the true exponent; masking is a readback matter
   assign cmp_bus.result_word = result_value;
   assign cmp_bus.limit_word = upper_threshold_reg;

   lux_limit_compare u_compare (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .cmp(cmp_bus)
   );

   // line sampling; inputs arrive synchronous, one stage for edges
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_in;
         sda_q_reg <= sda_in;
         scl_d_reg <= scl_q_reg;
         sda_d_reg <= sda_q_reg;
      end
   end

   // threshold register, whole word written on the low byte
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         upper_threshold_reg <= {upper_exponent_reset,
                                 upper_mantissa_reset};
      end else if (state_reg == st_rx && scl_fall && byte_full
                   && !rw_reg && write_hit) begin
         upper_threshold_reg <= write_word;
      end
   end

   // new-sample pulse toward the alert logic
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         new_sample_reg <= 1'b0;
      end else begin
         new_sample_reg <= sample_done;
      end
   end

   // serial target: start and stop win over any bit activity
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= st_idle;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_idx_reg <= 2'd0;
         rw_reg <= 1'b0;
         pointer_reg <= 8'h00;
         msb_hold_reg <= 8'h00;
         tx_reg <= 16'h0000;
         half_reg <= 1'b0;
         nack_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end else if (start_seen) begin
         state_reg <= st_rx;
         bit_cnt_reg <= 4'h0;
         byte_idx_reg <= 2'd0;
         sda_oe_reg <= 1'b0;
      end else if (stop_seen) begin
         state_reg <= st_idle;
         sda_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            st_rx: begin
               if (scl_rise && !byte_full) begin
                  shift_reg <= {shift_reg[6:0], sda_q_reg};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && byte_full) begin
                  bit_cnt_reg <= 4'h0;
                  if (byte_idx_reg == 2'd0) begin
                     // foreign address: stay off the bus until next start
                     state_reg <= addr_match ? st_ack : st_idle;
                     sda_oe_reg <= addr_match;
                     rw_reg <= shift_reg[0];
                     byte_idx_reg <= 2'd1;
                  end else begin
                     state_reg <= st_ack;
                     sda_oe_reg <= 1'b1;
                     if (byte_idx_reg == 2'd1) begin
                        pointer_reg <= shift_reg;
                        byte_idx_reg <= 2'd2;
                     end else if (byte_idx_reg == 2'd2) begin
                        msb_hold_reg <= shift_reg;
                        byte_idx_reg <= 2'd3;
                     end else begin
                        // further pairs rewrite the same register
                        byte_idx_reg <= 2'd2;
                     end
                  end
               end
            end
            st_ack: begin
               if (scl_fall) begin
                  bit_cnt_reg <= 4'h0;
                  if (rw_reg) begin
                     // first data bit goes out on this same fall
                     state_reg <= st_tx;
                     sda_oe_reg <= ~read_word[15];
                     tx_reg <= {read_word[14:0], 1'b0};
                     bit_cnt_reg <= 4'h1;
                     half_reg <= 1'b0;
                  end else begin
                     state_reg <= st_rx;
                     sda_oe_reg <= 1'b0;
                  end
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  if (byte_full) begin
                     state_reg <= st_rack;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     sda_oe_reg <= ~tx_reg[15];
                     tx_reg <= {tx_reg[14:0], 1'b0};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
            end
            st_rack: begin
               if (scl_rise) begin
                  nack_reg <= sda_q_reg;
               end else if (scl_fall) begin
                  if (nack_reg) begin
                     state_reg <= st_idle;
                  end else begin
                     state_reg <= st_tx;
                     sda_oe_reg <= ~tx_word[15];
                     tx_reg <= {tx_word[14:0], 1'b0};
                     bit_cnt_reg <= 4'h1;
                     half_reg <= ~half_reg;
                  end
               end
            end
            default: begin
               sda_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   assign sda_out = 1'b0; // open drain: only ever pulls low
   assign sda_oe = sda_oe_reg;
   assign upper_threshold = upper_threshold_reg;
   assign above_upper = cmp_bus.above_limit;
   assign new_sample = new_sample_reg;
endmodule : light_sensor_limit_id_regs

// >>> verilog/light_sensor_pkg.sv
package light_sensor_pkg;
   // register offsets (pointer values on the serial bus)
   localparam logic [7:0] upper_threshold_offset = 8'h03;
   localparam logic [7:0] maker_identifier_offset = 8'h7e;
   localparam logic [7:0] part_identifier_offset = 8'h7f;
   // field layout of the upper threshold register
   localparam int exponent_msb = 15;
   localparam int exponent_lsb = 12;
   localparam int mantissa_msb = 11;
   localparam int mantissa_lsb = 0;
   // reset values
   localparam logic [3:0] upper_exponent_reset = 4'hb;
   localparam logic [11:0] upper_mantissa_reset = 12'hfff;
   localparam logic [15:0] upper_threshold_reset = 16'hbfff;
   // lux value width: 12-bit mantissa shifted by up to 15
   localparam int lux_width = 27;
   // bit count of one serial byte
   localparam logic [3:0] bits_per_byte = 4'h8;

   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_rx = 3'b001,
      st_ack = 3'b010,
      st_tx = 3'b011,
      st_rack = 3'b100
   } target_state_type;
endpackage : light_sensor_pkg

// >>> verilog/limit_compare_if.sv
interface limit_compare_if;
   logic [15:0] result_word; // measurement, true exponent
   logic [15:0] limit_word; // upper threshold register
   logic above_limit; // registered comparison answer
   modport owner (output result_word, output limit_word, input above_limit);
   modport comparer (input result_word, input limit_word, output above_limit);
endinterface : limit_compare_if

// >>> verilog/lux_limit_compare.sv
module lux_limit_compare
   import light_sensor_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst_b, // asynchronous reset, active low
   limit_compare_if.comparer cmp // result and limit in, answer out
);
   // scales mantissa by its exponent; the common 0.01 lux factor cancels
   function automatic logic [lux_width-1:0] to_lux(input logic [15:0] w);
      logic [lux_width-1:0] m;
      m = {{(lux_width-12){1'b0}}, w[mantissa_msb:mantissa_lsb]};
      to_lux = m << w[exponent_msb:exponent_lsb];
   endfunction : to_lux

   wire logic [lux_width-1:0] result_lux;
   wire logic [lux_width-1:0] limit_lux;
   wire logic above_next;

   // both sides in lux so mixed exponents compare correctly
   assign result_lux = to_lux(cmp.result_word);
   assign limit_lux = to_lux(cmp.limit_word);
   assign above_next = result_lux > limit_lux;

   logic above_reg;
   // register the answer so the top sees a clean flop
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         above_reg <= 1'b0;
      end else begin
         above_reg <= above_next;
      end
   end
   assign cmp.above_limit = above_reg;
endmodule : lux_limit_compare
